/* File: core/tccc_pkg.sv */
// Constants and types shared by the compare/capture channel
package tccc_pkg;
  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_INTE = 4'h4;
  localparam logic [3:0] OFF_DATA = 4'h8;
  localparam logic [3:0] OFF_FLAG = 4'hc;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] INTE_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'hff7f;
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int SYNC_B = 15;
  localparam int BUF_HI = 14;
  localparam int BUF_LO = 12;
  localparam int SRC_HI = 11;
  localparam int SRC_LO = 10;
  localparam int EDG_HI = 9;
  localparam int EDG_LO = 8;
  localparam int PAIR_B = 6;
  localparam int SWLV_B = 5;
  localparam int OMD_HI = 4;
  localparam int OMD_LO = 2;
  localparam int CCSEL_B = 0;
  // ----------------------------------------------------------------
  // Interrupt cause positions
  // ----------------------------------------------------------------
  localparam int CH_INDEX = 0;
  localparam int IB_ZERO = 0;
  localparam int IB_MAX = 1;
  localparam int IB_CC = 2 + 2 * CH_INDEX;
  localparam int IB_OW = 3 + 2 * CH_INDEX;
  localparam logic [15:0] IE_MASK = 16'h0003 | (16'h000c << (2 * CH_INDEX));
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_SW_LO = 2'h2;
  localparam logic [1:0] SRC_SW_HI = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] OUT_SW = 3'h0;
  typedef enum logic [2:0] {
    BUF_WRITE = 3'h0,
    BUF_PERIOD = 3'h1,
    BUF_MATCH = 3'h2,
    BUF_WRAP = 3'h3,
    BUF_MATCH_RST = 3'h4
  } tccc_bufmd_e;
  typedef enum logic [1:0] {
    DIR_UP = 2'h0,
    DIR_DOWN = 2'h1,
    DIR_UPDN = 2'h2
  } tccc_dir_e;
endpackage : tccc_pkg

/* File: core/tccc_cnt_if.sv */
// Counter state carried to the channel submodules
`timescale 1ns/1ps
interface tccc_cnt_if;
  logic [15:0] value;
  logic step;
  logic at_max;
  logic at_zero;
  tccc_pkg::tccc_dir_e dir;
  modport src (output value, step, at_max, at_zero, dir);
  modport sink (input value, step, at_max, at_zero, dir);
endinterface : tccc_cnt_if

/* File: core/tccc_capture.sv */
// Capture trigger selection and counter sampling
`timescale 1ns/1ps
module tccc_capture (
  input wire logic clk,
  input wire logic rst,
  tccc_cnt_if.sink cnt,
  input wire logic enable,
  input wire logic sync_sel,
  input wire logic [1:0] src,
  input wire logic [1:0] edge_sel,
  input wire logic pin_lvl,
  input wire logic sw_rise,
  input wire logic sw_fall,
  output logic cap_evt,
  output logic [15:0] cap_val
);
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic rise,
    input logic fall
  );
    case (sel)
      tccc_pkg::EDGE_RISE: edge_hit = rise;
      tccc_pkg::EDGE_FALL: edge_hit = fall;
      tccc_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic prev_q, prev_d, pend_q, pend_d, evt_q, evt_d, trig;
  logic [15:0] val_q, val_d;

  always_comb begin
    trig = 1'b0;
    if (enable && src == tccc_pkg::SRC_PIN) begin
      trig = edge_hit(edge_sel, pin_lvl & ~prev_q, ~pin_lvl & prev_q);
    end else if (enable) begin
      trig = edge_hit(edge_sel, sw_rise, sw_fall);
    end
    prev_d = pin_lvl;
    pend_d = trig & sync_sel;
    evt_d = (trig & ~sync_sel) | pend_q;
    val_d = evt_d ? cnt.value : val_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
      evt_q <= 1'b0;
      val_q <= tccc_pkg::DATA_RST;
    end else begin
      prev_q <= prev_d;
      pend_q <= pend_d;
      evt_q <= evt_d;
      val_q <= val_d;
    end
  end

  assign cap_evt = evt_q;
  assign cap_val = val_q;
endmodule : tccc_capture

/* File: core/tccc_bufload.sv */
// Compare buffer and its load timing
`timescale 1ns/1ps
module tccc_bufload (
  input wire logic clk,
  input wire logic rst,
  tccc_cnt_if.sink cnt,
  input wire logic enable,
  input wire logic [2:0] code,
  input wire logic wr_pend,
  input wire logic [15:0] data,
  output logic match,
  output logic [15:0] buf_val,
  output logic cnt_clear,
  output logic cnt_load_max
);
  logic [15:0] buf_q, buf_d;
  logic hit, load, dn, ud;
  logic match_q, match_d, clr_q, clr_d, max_q, max_d;

  always_comb begin
    dn = cnt.dir == tccc_pkg::DIR_DOWN;
    ud = cnt.dir == tccc_pkg::DIR_UPDN;
    hit = enable & cnt.step & (cnt.value == buf_q);
    load = 1'b0;
    clr_d = 1'b0;
    max_d = 1'b0;
    case (code)
      tccc_pkg::BUF_WRITE: load = wr_pend;
      tccc_pkg::BUF_PERIOD: begin
        load = dn ? cnt.at_zero : ud ? (cnt.at_max | cnt.at_zero) : cnt.at_max;
      end
      tccc_pkg::BUF_MATCH: load = hit;
      tccc_pkg::BUF_WRAP: begin
        load = dn ? cnt.at_max : ud ? (hit | cnt.at_zero) : cnt.at_zero;
      end
      tccc_pkg::BUF_MATCH_RST: begin
        load = hit;
        clr_d = hit & ~dn;
        max_d = hit & dn;
      end
      default: load = 1'b0;
    endcase
    buf_d = (load & enable) ? data : buf_q;
    match_d = hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_q <= tccc_pkg::DATA_RST;
      match_q <= 1'b0;
      clr_q <= 1'b0;
      max_q <= 1'b0;
    end else begin
      buf_q <= buf_d;
      match_q <= match_d;
      clr_q <= clr_d;
      max_q <= max_d;
    end
  end

  assign match = match_q;
  assign buf_val = buf_q;
  assign cnt_clear = clr_q;
  assign cnt_load_max = max_q;
endmodule : tccc_bufload

/* File: core/tccc_top.sv */
// Compare/capture channel top with its register port
//
// How it works
// - Enable bit set lets its cause interrupt
// - Separate enables for zero, max, compare, overwrite
// - Enables of absent channels read zero
// - Sync bit picks synchronous or asynchronous capture
// - Buffer load code picks timing; reserved ignored
// - Code 0 loads on edge after write
// - Code 1 loads at max or zero
// - Code 2 loads on previous value match
// - Code 3 loads on counter wrap
// - Code 4 loads on match, resets counter
// - Source field picks pin or software trigger
// - Selected edge stores counter in data register
// - Edge code none, rise, fall or both
// - Source field change makes software trigger
// - Paired bit uses both comparator matches
// - Software mode drives output from level bit
// - Level bit one high, zero low
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tccc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic CAP_PIN,
  input wire logic [15:0] CNT_VALUE,
  input wire logic CNT_STEP,
  input wire logic CNT_AT_MAX,
  input wire logic CNT_AT_ZERO,
  input wire logic [1:0] CNT_DIR,
  input wire logic PAIR_MATCH,
  output logic MATCH,
  output logic TOUT,
  output logic IRQ,
  output logic CNT_CLEAR,
  output logic CNT_LOAD_MAX
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] inte_q, inte_d;
  logic [15:0] flag_q, flag_d;
  logic [15:0] data_q, data_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] flag_set;
  logic pend_q, pend_d;
  logic sw_rise_q, sw_rise_d;
  logic sw_fall_q, sw_fall_d;
  logic tout_q, tout_d;
  logic irq_q, irq_d;
  logic sync1_q, sync2_q;
  logic pin_hist_q;
  logic wr_ctrl, wr_inte, wr_data, wr_flag;
  logic cap_mode;
  logic [2:0] buf_code;
  logic [1:0] src_sel;
  logic [1:0] edge_sel;
  logic [2:0] out_mode;
  logic cap_evt;
  logic [15:0] cap_val;
  logic match_w;
  logic [15:0] buf_val;
  logic clr_w, max_w;

  tccc_cnt_if cnt_if ();

  assign cnt_if.value = CNT_VALUE;
  assign cnt_if.step = CNT_STEP;
  assign cnt_if.at_max = CNT_AT_MAX;
  assign cnt_if.at_zero = CNT_AT_ZERO;
  assign cnt_if.dir = tccc_pkg::tccc_dir_e'(CNT_DIR);

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign wr_ctrl = WR && (ADDR == tccc_pkg::OFF_CTRL);
  assign wr_inte = WR && (ADDR == tccc_pkg::OFF_INTE);
  assign wr_data = WR && (ADDR == tccc_pkg::OFF_DATA);
  assign wr_flag = WR && (ADDR == tccc_pkg::OFF_FLAG);
  assign cap_mode = ctrl_q[tccc_pkg::CCSEL_B];
  assign buf_code = ctrl_q[tccc_pkg::BUF_HI:tccc_pkg::BUF_LO];
  assign src_sel = ctrl_q[tccc_pkg::SRC_HI:tccc_pkg::SRC_LO];
  assign edge_sel = ctrl_q[tccc_pkg::EDG_HI:tccc_pkg::EDG_LO];
  assign out_mode = ctrl_q[tccc_pkg::OMD_HI:tccc_pkg::OMD_LO];

  // ----------------------------------------------------------------
  // Capture pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      pin_hist_q <= 1'b0;
    end else begin
      sync1_q <= CAP_PIN;
      sync2_q <= sync1_q;
      pin_hist_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tccc_capture u_capture (
    .clk(CLK),
    .rst(RST),
    .cnt(cnt_if.sink),
    .enable(cap_mode),
    .sync_sel(ctrl_q[tccc_pkg::SYNC_B]),
    .src(src_sel),
    .edge_sel(edge_sel),
    .pin_lvl(sync2_q),
    .sw_rise(sw_rise_q),
    .sw_fall(sw_fall_q),
    .cap_evt(cap_evt),
    .cap_val(cap_val)
  );

  tccc_bufload u_bufload (
    .clk(CLK),
    .rst(RST),
    .cnt(cnt_if.sink),
    .enable(~cap_mode),
    .code(buf_code),
    .wr_pend(pend_q),
    .data(data_q),
    .match(match_w),
    .buf_val(buf_val),
    .cnt_clear(clr_w),
    .cnt_load_max(max_w)
  );

  // ----------------------------------------------------------------
  // Registers, flags and output
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    inte_d = inte_q;
    data_d = data_q;
    pend_d = 1'b0;
    sw_rise_d = 1'b0;
    sw_fall_d = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = WDATA & tccc_pkg::CTL_WMASK;
      if (WDATA[tccc_pkg::CCSEL_B]) begin
        sw_rise_d = (src_sel == tccc_pkg::SRC_SW_LO) &&
          (WDATA[tccc_pkg::SRC_HI:tccc_pkg::SRC_LO] == tccc_pkg::SRC_SW_HI);
        sw_fall_d = (src_sel == tccc_pkg::SRC_SW_HI) &&
          (WDATA[tccc_pkg::SRC_HI:tccc_pkg::SRC_LO] == tccc_pkg::SRC_SW_LO);
      end
    end
    if (wr_inte) begin
      inte_d = WDATA & tccc_pkg::IE_MASK;
    end
    if (wr_data) begin
      data_d = WDATA;
      pend_d = 1'b1;
    end
    if (cap_evt) begin
      data_d = cap_val;
    end
  end

  always_comb begin
    flag_set = 16'h0000;
    flag_set[tccc_pkg::IB_ZERO] = CNT_AT_ZERO;
    flag_set[tccc_pkg::IB_MAX] = CNT_AT_MAX;
    flag_set[tccc_pkg::IB_CC] = cap_mode ? cap_evt : match_w;
    flag_set[tccc_pkg::IB_OW] = cap_mode & cap_evt &
      flag_q[tccc_pkg::IB_CC];
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = flag_q & ~WDATA;
    end
    flag_d = (flag_d | flag_set) & tccc_pkg::IE_MASK;
    irq_d = |(flag_q & inte_q);
  end

  always_comb begin
    tout_d = tout_q;
    if (!cap_mode) begin
      if (out_mode == tccc_pkg::OUT_SW) begin
        tout_d = ctrl_q[tccc_pkg::SWLV_B];
      end else if (ctrl_q[tccc_pkg::PAIR_B]) begin
        if (match_w) begin
          tout_d = 1'b0;
        end else if (PAIR_MATCH) begin
          tout_d = 1'b1;
        end
      end else if (match_w) begin
        tout_d = 1'b0;
      end else if (CNT_DIR == tccc_pkg::DIR_DOWN ? CNT_AT_ZERO
                                                 : CNT_AT_MAX) begin
        tout_d = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (RD) begin
      case (ADDR)
        tccc_pkg::OFF_CTRL: rdata_d = ctrl_q;
        tccc_pkg::OFF_INTE: rdata_d = inte_q;
        tccc_pkg::OFF_DATA: rdata_d = data_q;
        tccc_pkg::OFF_FLAG: rdata_d = flag_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= tccc_pkg::CTRL_RST;
      inte_q <= tccc_pkg::INTE_RST;
      flag_q <= tccc_pkg::FLAG_RST;
      data_q <= tccc_pkg::DATA_RST;
      rdata_q <= 16'h0000;
      pend_q <= 1'b0;
      sw_rise_q <= 1'b0;
      sw_fall_q <= 1'b0;
      tout_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      inte_q <= inte_d;
      flag_q <= flag_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      pend_q <= pend_d;
      sw_rise_q <= sw_rise_d;
      sw_fall_q <= sw_fall_d;
      tout_q <= tout_d;
      irq_q <= irq_d;
    end
  end

  assign RDATA = rdata_q;
  assign TOUT = tout_q;
  assign IRQ = irq_q;
  assign MATCH = match_w;
  assign CNT_CLEAR = clr_w;
  assign CNT_LOAD_MAX = max_w;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  property p_irq_off;
    ((flag_q & inte_q) == 16'h0000) [*2] |-> !IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt raised with no enabled cause");

  property p_irq_on;
    ((flag_q & inte_q) != 16'h0000) |=> IRQ;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled pending cause gave no interrupt");

  property p_inte_wr;
    wr_inte |=> RD && ADDR == tccc_pkg::OFF_INTE |=>
      RDATA == ($past(WDATA, 2) & tccc_pkg::IE_MASK);
  endproperty
  a_inte_wr: assert property (p_inte_wr)
    else $error("enable readback wrong");

  property p_ctl_rsvd;
    RD && ADDR == tccc_pkg::OFF_CTRL |=> RDATA[7] == 1'b0;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd)
    else $error("reserved control bit read as one");

  property p_buf_wr;
    wr_data && !cap_mode && buf_code == tccc_pkg::BUF_WRITE
      |=> ##1 buf_val == $past(WDATA, 2);
  endproperty
  a_buf_wr: assert property (p_buf_wr)
    else $error("compare buffer missed the written value");

  property p_buf_period;
    !cap_mode && buf_code == tccc_pkg::BUF_PERIOD && !pend_q &&
      CNT_DIR == tccc_pkg::DIR_UP && CNT_AT_MAX
      |=> buf_val == $past(data_q);
  endproperty
  a_buf_period: assert property (p_buf_period)
    else $error("buffer not loaded at counter max");

  property p_buf_rsvd;
    buf_code > tccc_pkg::BUF_MATCH_RST |=> $stable(buf_val);
  endproperty
  a_buf_rsvd: assert property (p_buf_rsvd)
    else $error("reserved load code changed the buffer");

  property p_match_rst;
    !cap_mode && buf_code == tccc_pkg::BUF_MATCH_RST && CNT_STEP &&
      CNT_VALUE == buf_val && CNT_DIR != tccc_pkg::DIR_DOWN
      |=> CNT_CLEAR && !CNT_LOAD_MAX;
  endproperty
  a_match_rst: assert property (p_match_rst)
    else $error("match did not clear the counter");

  property p_sw_level;
    !cap_mode && out_mode == tccc_pkg::OUT_SW
      |=> TOUT == $past(ctrl_q[tccc_pkg::SWLV_B]);
  endproperty
  a_sw_level: assert property (p_sw_level)
    else $error("output does not follow the level bit");

  property p_cap_rise;
    cap_mode && !ctrl_q[tccc_pkg::SYNC_B] && src_sel == tccc_pkg::SRC_PIN
      && edge_sel == tccc_pkg::EDGE_RISE && sync2_q && !pin_hist_q
      |=> cap_evt ##1 data_q == $past(CNT_VALUE, 2);
  endproperty
  a_cap_rise: assert property (p_cap_rise)
    else $error("rising pin edge not captured");

  property p_cap_none;
    (edge_sel == 2'h0) [*3] |-> !cap_evt;
  endproperty
  a_cap_none: assert property (p_cap_none)
    else $error("capture with edge selection off");

  property p_sw_trig;
    wr_ctrl && cap_mode && src_sel == tccc_pkg::SRC_SW_LO &&
      WDATA[tccc_pkg::SRC_HI:tccc_pkg::SRC_LO] == tccc_pkg::SRC_SW_HI &&
      WDATA[tccc_pkg::EDG_HI:tccc_pkg::EDG_LO] == tccc_pkg::EDGE_RISE &&
      WDATA[tccc_pkg::CCSEL_B] && !WDATA[tccc_pkg::SYNC_B]
      |=> ##1 cap_evt;
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("software trigger not captured");

  c_capture: cover property (cap_mode && cap_evt);
  c_load: cover property (!cap_mode && $changed(buf_val));
  c_irq: cover property ($rose(IRQ));
  c_pair: cover property (ctrl_q[tccc_pkg::PAIR_B] && $rose(TOUT));
endmodule : tccc_top

/* File: dv/tccc_cnt_model.sv */
// Counter block model driving the channel's counter inputs
`timescale 1ns/1ps
module tccc_cnt_model #(
  parameter logic [15:0] MAXV = 16'h001f
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] dir,
  input wire logic clear,
  input wire logic load_max,
  output logic [15:0] value,
  output logic step,
  output logic at_max,
  output logic at_zero
);
  logic [15:0] nx;
  logic mv;
  // ----------------------------------------------------------------
  // Counting, clear and reload
  // ----------------------------------------------------------------
  always_comb begin
    nx = value;
    mv = 1'b1;
    if (clear) begin
      nx = 16'h0000;
    end else if (load_max) begin
      nx = MAXV;
    end else if (!run) begin
      mv = 1'b0;
    end else if (dir == 2'h1) begin
      nx = (value == 16'h0000) ? MAXV : value - 16'h0001;
    end else begin
      nx = (value == MAXV) ? 16'h0000 : value + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      value <= 16'h0000;
      step <= 1'b0;
      at_max <= 1'b0;
      at_zero <= 1'b0;
    end else begin
      value <= nx;
      step <= mv;
      at_max <= mv && (nx == MAXV);
      at_zero <= mv && (nx == 16'h0000);
    end
  end
endmodule : tccc_cnt_model

/* File: dv/tb_top.sv */
// Self-checking bench for the compare/capture channel
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CAP_PIN = 1'b0;
  logic PAIR_MATCH = 1'b0;
  logic run = 1'b0;
  logic restart = 1'b0;
  logic [1:0] dir = 2'h0;
  logic [15:0] RDATA, cnt_value, prev_cnt;
  logic cnt_step, cnt_max, cnt_zero, clr_seen, max_seen;
  logic MATCH, TOUT, IRQ, CNT_CLEAR, CNT_LOAD_MAX;
  int bad_count = 0;
  int check_count = 0;
  always #4 CLK = ~CLK;
  tccc_top u_tccc_top (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CAP_PIN(CAP_PIN),
    .CNT_VALUE(cnt_value), .CNT_STEP(cnt_step), .CNT_AT_MAX(cnt_max),
    .CNT_AT_ZERO(cnt_zero), .CNT_DIR(dir), .PAIR_MATCH(PAIR_MATCH),
    .MATCH(MATCH), .TOUT(TOUT), .IRQ(IRQ), .CNT_CLEAR(CNT_CLEAR),
    .CNT_LOAD_MAX(CNT_LOAD_MAX));
  tccc_cnt_model #(.MAXV(16'h001f)) u_tccc_cnt_model (.clk(CLK),
    .rst(RST), .run(run), .restart(restart), .dir(dir),
    .clear(CNT_CLEAR), .load_max(CNT_LOAD_MAX), .value(cnt_value),
    .step(cnt_step), .at_max(cnt_max), .at_zero(cnt_zero));
  always @(posedge CLK) begin
    prev_cnt <= cnt_value;
    if (restart) begin
      clr_seen <= 1'b0;
      max_seen <= 1'b0;
    end else begin
      if (CNT_CLEAR === 1'b1) clr_seen <= 1'b1;
      if (CNT_LOAD_MAX === 1'b1) max_seen <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : settle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk("register read", e, d);
  endtask : rchk
  task automatic go();
    @(posedge CLK);
    run <= 1'b0;
    restart <= 1'b1;
    @(posedge CLK);
    restart <= 1'b0;
    run <= 1'b1;
  endtask : go
  task automatic wait_match(input logic [15:0] e);
    for (int i = 0; i < 200; i++) begin
      @(negedge CLK);
      if (MATCH === 1'b1) begin
        chk("match point", e, prev_cnt);
        return;
      end
    end
    chk("match timeout", 16'h0001, 16'h0000);
    finish_test();
  endtask : wait_match
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reg_check();
    rchk(tccc_pkg::OFF_CTRL, 16'h0000);
    rchk(tccc_pkg::OFF_INTE, 16'h0000);
    wr(tccc_pkg::OFF_CTRL, 16'hffff);
    rchk(tccc_pkg::OFF_CTRL, 16'hff7f);
    wr(tccc_pkg::OFF_INTE, 16'hffff);
    rchk(tccc_pkg::OFF_INTE, 16'h000f);
    @(posedge CLK);
    ADDR <= tccc_pkg::OFF_INTE;
    WDATA <= 16'hfff5;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("enable readback", 16'h0005, RDATA);
    wr(4'h2, 16'hffff);
    rchk(4'h2, 16'h0000);
    wr(tccc_pkg::OFF_CTRL, 16'h0000);
    wr(tccc_pkg::OFF_INTE, 16'h0000);
  endtask : reg_check
  task automatic buf_case(input logic [2:0] c, input logic [15:0] v,
                          input logic [15:0] m1, input logic [15:0] m2);
    @(posedge CLK);
    run <= 1'b0;
    wr(tccc_pkg::OFF_CTRL, {1'b0, c, 12'h000});
    wr(tccc_pkg::OFF_DATA, v);
    go();
    wait_match(m1);
    wait_match(m2);
    chk("clear", {15'h0, c == 3'h4 && !dir[0]}, {15'h0, clr_seen});
    chk("to max", {15'h0, c == 3'h4 && dir[0]}, {15'h0, max_seen});
  endtask : buf_case
  task automatic down_case();
    @(posedge CLK);
    dir <= 2'h1;
    buf_case(3'h4, 16'h0018, 16'h000d, 16'h0018);
    @(posedge CLK);
    run <= 1'b0;
    dir <= 2'h0;
  endtask : down_case
  task automatic tout_case();
    wr(tccc_pkg::OFF_CTRL, 16'h0020);
    settle(2);
    chk("tout level", 16'h0001, {15'h0, TOUT});
    wr(tccc_pkg::OFF_CTRL, 16'h0000);
    settle(2);
    chk("tout level", 16'h0000, {15'h0, TOUT});
    wr(tccc_pkg::OFF_DATA, 16'h000d);
    wr(tccc_pkg::OFF_CTRL, 16'h005c);
    @(posedge CLK);
    PAIR_MATCH <= 1'b1;
    @(posedge CLK);
    PAIR_MATCH <= 1'b0;
    settle(2);
    chk("paired set", 16'h0001, {15'h0, TOUT});
    go();
    wait_match(16'h000d);
    settle(2);
    chk("paired reset", 16'h0000, {15'h0, TOUT});
    @(posedge CLK);
    run <= 1'b0;
  endtask : tout_case
  task automatic pin_step(input logic lv, input logic e);
    logic [15:0] f;
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    @(posedge CLK);
    CAP_PIN <= lv;
    settle(8);
    rd(tccc_pkg::OFF_FLAG, f);
    chk("pin capture", {15'h0, e}, {15'h0, f[2]});
  endtask : pin_step
  task automatic cap_edges();
    logic [15:0] f;
    for (int e = 0; e < 4; e++) begin
      wr(tccc_pkg::OFF_CTRL, {6'h00, 2'(e), 8'h01});
      pin_step(1'b1, e[0]);
      pin_step(1'b0, e[1]);
    end
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    @(posedge CLK);
    CAP_PIN <= 1'b1;
    settle(8);
    @(posedge CLK);
    CAP_PIN <= 1'b0;
    settle(8);
    rd(tccc_pkg::OFF_FLAG, f);
    chk("overwrite flag", 16'h000c, f & 16'h000c);
  endtask : cap_edges
  task automatic cap_sync();
    logic [15:0] a, b, ca, cb;
    wr(tccc_pkg::OFF_CTRL, 16'h0101);
    go();
    @(posedge CLK);
    CAP_PIN <= 1'b1;
    #1 ca = cnt_value;
    settle(8);
    rd(tccc_pkg::OFF_DATA, a);
    @(posedge CLK);
    CAP_PIN <= 1'b0;
    wr(tccc_pkg::OFF_CTRL, 16'h8101);
    go();
    @(posedge CLK);
    CAP_PIN <= 1'b1;
    #1 cb = cnt_value;
    settle(8);
    rd(tccc_pkg::OFF_DATA, b);
    chk("sync delay", a - ca + 16'h0001, b - cb);
    @(posedge CLK);
    run <= 1'b0;
  endtask : cap_sync
  task automatic sw_trig();
    logic [15:0] f;
    wr(tccc_pkg::OFF_CTRL, 16'h0901);
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    wr(tccc_pkg::OFF_CTRL, 16'h0d01);
    settle(8);
    rd(tccc_pkg::OFF_FLAG, f);
    chk("soft rise", 16'h0001, {15'h0, f[2]});
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    wr(tccc_pkg::OFF_CTRL, 16'h0901);
    settle(8);
    rd(tccc_pkg::OFF_FLAG, f);
    chk("soft none", 16'h0000, {15'h0, f[2]});
    wr(tccc_pkg::OFF_CTRL, 16'h0e01);
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    wr(tccc_pkg::OFF_CTRL, 16'h0a01);
    settle(8);
    rd(tccc_pkg::OFF_FLAG, f);
    chk("soft fall", 16'h0001, {15'h0, f[2]});
  endtask : sw_trig
  task automatic irq_case();
    wr(tccc_pkg::OFF_INTE, 16'h0004);
    settle(3);
    chk("irq on", 16'h0001, {15'h0, IRQ});
    wr(tccc_pkg::OFF_INTE, 16'h0000);
    settle(3);
    chk("irq off", 16'h0000, {15'h0, IRQ});
    wr(tccc_pkg::OFF_CTRL, 16'h0000);
    wr(tccc_pkg::OFF_FLAG, 16'h000f);
    wr(tccc_pkg::OFF_INTE, 16'h0001);
    settle(3);
    chk("irq clean", 16'h0000, {15'h0, IRQ});
    go();
    for (int i = 0; i < 100; i++) begin
      @(negedge CLK);
      if (IRQ === 1'b1) break;
    end
    chk("irq zero", 16'h0001, {15'h0, IRQ});
    @(posedge CLK);
    run <= 1'b0;
  endtask : irq_case
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    reg_check();
    buf_case(3'h0, 16'h0005, 16'h0005, 16'h0005);
    buf_case(3'h1, 16'h0009, 16'h0005, 16'h0009);
    buf_case(3'h2, 16'h0003, 16'h0009, 16'h0003);
    buf_case(3'h3, 16'h0007, 16'h0003, 16'h0007);
    buf_case(3'h4, 16'h000d, 16'h0007, 16'h000d);
    buf_case(3'h5, 16'h0004, 16'h000d, 16'h000d);
    down_case();
    tout_case();
    cap_edges();
    cap_sync();
    sw_trig();
    irq_case();
    finish_test();
  end
endmodule : tb_top
